// File: qrwp_cfg.svh
// Constants of the quad read, wrap and page program sequencer.
// Included by the package and the core; holds definitions only.
`ifndef QRWP_CFG_SVH
`define QRWP_CFG_SVH
// *****************************
// Opcodes
// *****************************
`define QRWP_OP_NONE 8'h00
`define QRWP_OP_WREN 8'h06
`define QRWP_OP_WRDI 8'h04
`define QRWP_OP_PROG 8'h02
`define QRWP_OP_QREAD 8'hEB
`define QRWP_OP_QWORD 8'hE7
`define QRWP_OP_WRAP 8'h77
`define QRWP_OP_CRMRST 8'hFF
// *****************************
// Fields and reset values
// *****************************
`define QRWP_CRM_KEEP 2'h2
`define QRWP_MODE_HI 5
`define QRWP_MODE_LO 4
`define QRWP_WRAP_HI 6
`define QRWP_WRAP_LO 4
`define QRWP_WRAP_DIS_BIT 0
`define QRWP_WRAP_RESET 3'h1
// *****************************
// Link phase lengths, last clock index
// *****************************
`define QRWP_LAST_BIT 5'h07
`define QRWP_LAST_QADDR 5'h05
`define QRWP_LAST_QMODE 5'h01
`define QRWP_LAST_QDUM_EB 5'h03
`define QRWP_LAST_QDUM_E7 5'h01
`define QRWP_LAST_SADDR 5'h17
`define QRWP_LAST_WDUM 5'h17
// *****************************
// Timing
// *****************************
`define QRWP_CLK_MHZ 10
`define QRWP_PP_TIME_US 700
`endif

// File: qrwp_core.sv
// Serial flash command core: quad reads with continuous mode and wrap, page program.
// Assumes an SPI host on cs_n_i/sck_i/io, an asynchronous array read port and
// an array write port; sck_i stops while cs_n_i is high.
`include "qrwp_cfg.svh"
module qrwp_core
    import qrwp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `QRWP_PP_TIME_US * `QRWP_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic io_oe_n_o,
    output logic [23:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    input wire logic quad_io_enable_i,
    input wire logic prot_en_i,
    input wire logic [15:0] prot_base_i,
    output qrwp_arr_t arr_o,
    output logic progress_flag_o,
    output logic write_latch_flag_o,
    output logic [2:0] wrap_setting_bits_o
);

    // *****************************
    // Declarations
    // *****************************
    qrwp_phase_t phase_r;
    qrwp_phase_t ph;
    qrwp_pstate_t ps_r;
    qrwp_frame_t fr;
    qrwp_arr_t arr_r;
    logic started_r;
    logic fid_r;
    logic [4:0] cnt_r;
    logic [4:0] cn;
    logic [7:0] sh_r;
    logic [7:0] sin;
    logic [7:0] op_r;
    logic [23:0] addr_r;
    logic [7:0] mode_r;
    logic [2:0] wbits_r;
    logic addr_ok_r;
    logic mode_ok_r;
    logic wrap_ok_r;
    logic [8:0] nbytes_r;
    logic [2:0] nbit_r;
    logic [7:0] idx_r;
    logic nib_r;
    logic [23:0] rd_addr_r;
    logic [3:0] io_r;
    logic [3:0] hold_r;
    logic io_oe_n_r;
    logic [7:0] buf_mem [0:255];
    logic [255:0] valid_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic fid_s1_r;
    logic fid_s2_r;
    logic fid_seen_r;
    logic qe_s1_r;
    logic qe_s2_r;
    logic pen_s1_r;
    logic pen_s2_r;
    logic [15:0] pbase_s1_r;
    logic [15:0] pbase_s2_r;
    logic crm_r;
    logic [7:0] crm_op_r;
    logic [2:0] wrap_r;
    logic wel_r;
    logic progress_r;
    logic [7:0] pidx_r;
    logic [15:0] pbase_r;
    logic [15:0] tmr_r;
    logic eval;
    logic prot;
    logic is_prog;
    logic start;
    logic abort;
    logic tmr_done;

    // Next read address, wrapped inside the aligned section when enabled
    function automatic logic [23:0] qrwp_next(input logic [23:0] a, input logic [2:0] w);
        logic [23:0] n;
        logic [5:0] m;
        n = a + 24'h000001;
        m = 6'h3F >> (2'h3 - w[2:1]);
        if (!w[`QRWP_WRAP_DIS_BIT]) begin
            n = {a[23:6], (a[5:0] & ~m) | (n[5:0] & m)};
        end
        return n;
    endfunction

    // *****************************
    // Link domain: frame decode
    // *****************************
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // Mode and wrap come from clk_i flops that only change with cs_n_i high; the enable follows quad_io_enable_i at any time
    always_comb begin
        ph = phase_r;
        cn = cnt_r;
        if (!started_r) begin
            ph = crm_r ? QRWP_PH_QADDR : QRWP_PH_CMD;
            cn = 5'h00;
        end
        sin = {sh_r[6:0], io_i[0]};
    end

    always_ff @(posedge sck_i) begin
        phase_r <= ph;
        cnt_r <= cn + 5'h01;
        sh_r <= sin;
        nbit_r <= started_r ? nbit_r + 3'h1 : 3'h1;
        if (!started_r) begin
            // Differs from the last evaluated id, so it is never unknown after reset
            fid_r <= ~fid_seen_r;
            op_r <= crm_r ? crm_op_r : `QRWP_OP_NONE;
            addr_ok_r <= 1'b0;
            mode_ok_r <= 1'b0;
            wrap_ok_r <= 1'b0;
            nbytes_r <= 9'h000;
        end
        unique case (ph)
            QRWP_PH_CMD: begin
                if (cn == `QRWP_LAST_BIT) begin
                    op_r <= sin;
                    cnt_r <= 5'h00;
                    if ((sin == `QRWP_OP_QREAD || sin == `QRWP_OP_QWORD) && qe_s2_r) begin
                        phase_r <= QRWP_PH_QADDR;
                    end else if (sin == `QRWP_OP_PROG && ps_r == QRWP_PS_IDLE) begin
                        phase_r <= QRWP_PH_SADDR;
                    end else if (sin == `QRWP_OP_WRAP) begin
                        phase_r <= QRWP_PH_WDUM;
                    end else begin
                        phase_r <= QRWP_PH_IGN;
                    end
                end
            end
            QRWP_PH_QADDR: begin
                addr_r <= {addr_r[19:0], io_i};
                if (cn == `QRWP_LAST_QADDR) begin
                    phase_r <= QRWP_PH_QMODE;
                    cnt_r <= 5'h00;
                end
            end
            QRWP_PH_QMODE: begin
                mode_r <= {mode_r[3:0], io_i};
                if (cn == `QRWP_LAST_QMODE) begin
                    mode_ok_r <= 1'b1;
                    phase_r <= QRWP_PH_QDUM;
                    cnt_r <= 5'h00;
                end
            end
            QRWP_PH_QDUM: begin
                if (cn == (op_r == `QRWP_OP_QWORD ? `QRWP_LAST_QDUM_E7 : `QRWP_LAST_QDUM_EB)) begin
                    phase_r <= QRWP_PH_QOUT;
                    rd_addr_r <= addr_r;
                    nib_r <= 1'b0;
                end
            end
            QRWP_PH_QOUT: begin
                nib_r <= ~nib_r;
                if (nib_r) begin
                    rd_addr_r <= qrwp_next(rd_addr_r, wrap_r);
                end
            end
            QRWP_PH_SADDR: begin
                addr_r <= {addr_r[22:0], io_i[0]};
                if (cn == `QRWP_LAST_SADDR) begin
                    addr_ok_r <= 1'b1;
                    idx_r <= {addr_r[6:0], io_i[0]};
                    phase_r <= QRWP_PH_SDATA;
                    cnt_r <= 5'h00;
                end
            end
            QRWP_PH_SDATA: begin
                if (cn == `QRWP_LAST_BIT) begin
                    cnt_r <= 5'h00;
                    idx_r <= idx_r + 8'h01;
                    if (nbytes_r != 9'h100) begin
                        nbytes_r <= nbytes_r + 9'h001;
                    end
                end
            end
            QRWP_PH_WDUM: begin
                if (cn == `QRWP_LAST_WDUM) begin
                    phase_r <= QRWP_PH_WBITS;
                    cnt_r <= 5'h00;
                end
            end
            QRWP_PH_WBITS: begin
                if (cn == `QRWP_LAST_BIT) begin
                    wbits_r <= sin[`QRWP_WRAP_HI:`QRWP_WRAP_LO];
                    wrap_ok_r <= 1'b1;
                    phase_r <= QRWP_PH_IGN;
                end
            end
            QRWP_PH_IGN: begin
            end
            default: begin
                phase_r <= QRWP_PH_IGN;
            end
        endcase
    end

    // Later bytes overwrite earlier ones at the same page index
    always_ff @(posedge sck_i) begin
        if (ph == QRWP_PH_SDATA && cn == `QRWP_LAST_BIT) begin
            buf_mem[idx_r] <= sin;
        end
    end

    for (genvar g = 0; g < 256; g++) begin : g_valid
        always_ff @(posedge sck_i) begin
            if (ph == QRWP_PH_SADDR && cn == `QRWP_LAST_SADDR) begin
                valid_r[g] <= 1'b0;
            end else if (ph == QRWP_PH_SDATA && cn == `QRWP_LAST_BIT && idx_r == 8'(g)) begin
                valid_r[g] <= 1'b1;
            end
        end
    end

    // *****************************
    // Link domain: quad output
    // *****************************
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            io_oe_n_r <= 1'b1;
            io_r <= 4'h0;
            hold_r <= 4'h0;
        end else if (started_r && phase_r == QRWP_PH_QOUT) begin
            io_oe_n_r <= 1'b0;
            if (!nib_r) begin
                io_r <= rd_data_i[7:4];
                hold_r <= rd_data_i[3:0];
            end else begin
                io_r <= hold_r;
            end
        end else begin
            io_oe_n_r <= 1'b1;
        end
    end

    // *****************************
    // Crossing into clk_i
    // *****************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            fid_s1_r <= 1'b0;
            fid_s2_r <= 1'b0;
            qe_s1_r <= 1'b1;
            qe_s2_r <= 1'b1;
            pen_s1_r <= 1'b0;
            pen_s2_r <= 1'b0;
            pbase_s1_r <= 16'h0000;
            pbase_s2_r <= 16'h0000;
        end else begin
            cs_s1_r <= cs_n_i;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            fid_s1_r <= fid_r;
            fid_s2_r <= fid_s1_r;
            qe_s1_r <= quad_io_enable_i;
            qe_s2_r <= qe_s1_r;
            pen_s1_r <= prot_en_i;
            pen_s2_r <= pen_s1_r;
            pbase_s1_r <= prot_base_i;
            pbase_s2_r <= pbase_s1_r;
        end
    end

    // Frame registers are quiet once chip select is high
    always_comb begin
        fr.op = op_r;
        fr.addr = addr_r;
        fr.addr_ok = addr_ok_r;
        fr.mode_ok = mode_ok_r;
        fr.mode = mode_r;
        fr.wrap_ok = wrap_ok_r;
        fr.wrap = wbits_r;
        fr.nbytes = nbytes_r;
        fr.aligned = (nbit_r == 3'h0);
    end

    assign eval = cs_s2_r && !cs_s3_r && (fid_s2_r != fid_seen_r);
    assign prot = pen_s2_r && (fr.addr[23:8] >= pbase_s2_r);
    assign is_prog = eval && fr.op == `QRWP_OP_PROG && wel_r && ps_r == QRWP_PS_IDLE;
    assign start = is_prog && fr.addr_ok && fr.nbytes != 9'h000 && fr.aligned && !prot;
    assign abort = is_prog && !start;
    assign tmr_done = (tmr_r == 16'(PROG_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fid_seen_r <= 1'b0;
        end else if (eval) begin
            fid_seen_r <= fid_s2_r;
        end
    end

    // *****************************
    // Persistent mode and wrap state
    // *****************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            crm_r <= 1'b0;
            crm_op_r <= `QRWP_OP_QREAD;
            wrap_r <= `QRWP_WRAP_RESET;
        end else if (eval) begin
            if (fr.op == `QRWP_OP_QREAD || fr.op == `QRWP_OP_QWORD) begin
                crm_r <= fr.mode_ok && fr.mode[`QRWP_MODE_HI:`QRWP_MODE_LO] == `QRWP_CRM_KEEP;
                crm_op_r <= fr.op;
            end else begin
                crm_r <= 1'b0;
            end
            if (fr.op == `QRWP_OP_WRAP && fr.wrap_ok && fr.aligned) begin
                wrap_r <= fr.wrap;
            end
        end
    end

    // *****************************
    // Write latch and program sequencer
    // *****************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wel_r <= 1'b0;
        end else if (eval && fr.op == `QRWP_OP_WREN && ps_r == QRWP_PS_IDLE) begin
            wel_r <= 1'b1;
        end else if ((eval && fr.op == `QRWP_OP_WRDI) || abort || start) begin
            wel_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ps_r <= QRWP_PS_IDLE;
            pidx_r <= 8'h00;
            pbase_r <= 16'h0000;
            tmr_r <= 16'h0000;
        end else begin
            unique case (ps_r)
                QRWP_PS_IDLE: begin
                    if (start) begin
                        ps_r <= QRWP_PS_WRITE;
                        pidx_r <= 8'h00;
                        pbase_r <= fr.addr[23:8];
                    end
                end
                QRWP_PS_WRITE: begin
                    pidx_r <= pidx_r + 8'h01;
                    if (pidx_r == 8'hFF) begin
                        ps_r <= QRWP_PS_WAIT;
                        tmr_r <= 16'h0000;
                    end
                end
                QRWP_PS_WAIT: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_done) begin
                        ps_r <= QRWP_PS_IDLE;
                    end
                end
                default: begin
                    ps_r <= QRWP_PS_IDLE;
                end
            endcase
        end
    end

    // Only sent bytes are written; the rest of the page keeps its erased value
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            arr_r <= '0;
        end else begin
            arr_r.we <= (ps_r == QRWP_PS_WRITE) && valid_r[pidx_r];
            arr_r.addr <= {pbase_r, pidx_r};
            arr_r.data <= buf_mem[pidx_r];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            progress_r <= 1'b0;
        end else if (start) begin
            progress_r <= 1'b1;
        end else if (ps_r == QRWP_PS_WAIT && tmr_done) begin
            progress_r <= 1'b0;
        end
    end

    assign io_o = io_r;
    assign io_oe_n_o = io_oe_n_r;
    assign rd_addr_o = rd_addr_r;
    assign arr_o = arr_r;
    assign progress_flag_o = progress_r;
    assign write_latch_flag_o = wel_r;
    assign wrap_setting_bits_o = wrap_r;

    // *****************************
    // Assertions
    // *****************************
    a_prog_needs_wel: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        eval && fr.op == `QRWP_OP_PROG && !wel_r && ps_r == QRWP_PS_IDLE |=> ps_r == QRWP_PS_IDLE)
        else $error("program started without write latch");
    a_abort_clears_wel: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        abort |=> !wel_r && !progress_r && ps_r == QRWP_PS_IDLE)
        else $error("aborted program left latch or busy");
    a_prot_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        eval && fr.op == `QRWP_OP_PROG && prot |=> ps_r == QRWP_PS_IDLE)
        else $error("protected page programmed");
    a_wel_before_done: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(progress_r) |-> !wel_r && ps_r == QRWP_PS_WRITE)
        else $error("latch not cleared at program start");
    a_progress_ends: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ps_r == QRWP_PS_WAIT && tmr_done |=> !progress_r ##1 !arr_r.we)
        else $error("busy did not end with program");
    a_write_in_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        arr_r.we |-> $past(ps_r == QRWP_PS_WRITE) && progress_r)
        else $error("array written outside program pass");
    a_crm_reset_cmd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        eval && fr.op == `QRWP_OP_CRMRST |=> !crm_r)
        else $error("continuous mode survived reset command");
    a_wrap_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        eval && fr.op == `QRWP_OP_WRAP && fr.wrap_ok && fr.aligned |=> wrap_r == $past(fr.wrap))
        else $error("wrap bits not stored");
    a_page_index_wrap: assert property (@(posedge sck_i) disable iff (cs_n_i)
        ph == QRWP_PH_SDATA && cn == `QRWP_LAST_BIT |=> idx_r == $past(idx_r) + 8'h01)
        else $error("buffer index did not advance in page");
    a_drive_in_output: assert property (@(negedge sck_i) disable iff (cs_n_i)
        !io_oe_n_r |-> phase_r == QRWP_PH_QOUT)
        else $error("io driven outside data output");

endmodule // qrwp_core

// File: qrwp_host.sv
// SPI host model that faces the quad read, wrap and page program core.
// Assumes mode 0 framing, a 32 ns link clock that runs only inside frames.
module qrwp_host (
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] io_o,
    input wire logic [3:0] dev_io_i,
    input wire logic dev_oe_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drv = 4'h0;
    logic drv_en = 1'b0;
    logic oe_seen;
    logic [7:0] rq [8];
    // Released lines show the inverse of the last driven value
    assign io_o = !dev_oe_n_i ? dev_io_i : (drv_en ? drv : ~drv);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
    end
    task automatic clk1();
        #16 sck_o = 1'b1;
        #16 sck_o = 1'b0;
    endtask
    // Shifts n bits MSB first, w lines per clock
    task automatic put(input logic [39:0] v, input int n, input int w);
        for (int i = n - w; i >= 0; i -= w) begin
            drv = (w == 4) ? v[i+:4] : {3'h0, v[i]};
            drv_en = 1'b1;
            clk1();
        end
    endtask
    task automatic start();
        cs_n_o = 1'b0;
        #20;
    endtask
    task automatic stop();
        #20 cs_n_o = 1'b1;
        drv_en = 1'b0;
        #600;
    endtask
    task automatic cmd(input logic [39:0] v, input int n);
        start();
        put(v, n, 1);
        stop();
    endtask
    // Opcode 00 means a continuous-mode frame without opcode
    task automatic qread(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                         input int nd, input int n);
        oe_seen = 1'b0;
        start();
        if (op != 8'h00) begin
            put({32'h0, op}, 8, 1);
        end
        put({16'h0, a}, 24, 4);
        put({32'h0, m}, 8, 4);
        drv_en = 1'b0;
        repeat (nd) clk1();
        for (int b = 0; b < n; b++) begin
            for (int h = 1; h >= 0; h--) begin
                #8 rq[b][h*4+:4] = io_o;
                oe_seen = oe_seen | !dev_oe_n_i;
                clk1();
            end
        end
        stop();
    endtask
endmodule // qrwp_host

// File: qrwp_pkg.sv
// Types of the quad read, wrap and page program sequencer.
// Assumes qrwp_cfg.svh is on the include path.
package qrwp_pkg;
    `include "qrwp_cfg.svh"

    // *****************************
    // Link phases
    // *****************************
    typedef enum logic [9:0] {
        QRWP_PH_CMD   = 10'h001,
        QRWP_PH_QADDR = 10'h002,
        QRWP_PH_QMODE = 10'h004,
        QRWP_PH_QDUM  = 10'h008,
        QRWP_PH_QOUT  = 10'h010,
        QRWP_PH_SADDR = 10'h020,
        QRWP_PH_SDATA = 10'h040,
        QRWP_PH_WDUM  = 10'h080,
        QRWP_PH_WBITS = 10'h100,
        QRWP_PH_IGN   = 10'h200
    } qrwp_phase_t;

    // *****************************
    // Program sequencer states
    // *****************************
    typedef enum logic [2:0] {
        QRWP_PS_IDLE  = 3'h1,
        QRWP_PS_WRITE = 3'h2,
        QRWP_PS_WAIT  = 3'h4
    } qrwp_pstate_t;

    // Frame summary, stable while chip select is high
    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
        logic addr_ok;
        logic mode_ok;
        logic [7:0] mode;
        logic wrap_ok;
        logic [2:0] wrap;
        logic [8:0] nbytes;
        logic aligned;
    } qrwp_frame_t;

    // Array write port
    typedef struct packed {
        logic we;
        logic [23:0] addr;
        logic [7:0] data;
    } qrwp_arr_t;
endpackage

// File: quad_read_wrap_page_program_bench.sv
// Self-checking bench of the quad read, wrap and page program core.
// Assumes qrwp_pkg and qrwp_host; the array is a small memory model here.
module quad_read_wrap_page_program_bench
    import qrwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic qen = 1'b1;
    logic prot_en = 1'b0;
    logic cs_n, sck, oe_n, progress, latch;
    logic [3:0] io_line, io_dev;
    logic [23:0] rd_addr;
    logic [2:0] wrap;
    qrwp_arr_t arr;
    logic [7:0] mem [0:1023];
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    qrwp_host i_host (.cs_n_o(cs_n), .sck_o(sck), .io_o(io_line), .dev_io_i(io_dev),
                      .dev_oe_n_i(oe_n));
    qrwp_core #(.PROG_CYCLES(20)) i_dut (.clk_i(clk), .reset_n_i(reset_n), .sck_i(sck),
        .cs_n_i(cs_n), .io_i(io_line), .io_o(io_dev), .io_oe_n_o(oe_n), .rd_addr_o(rd_addr),
        .rd_data_i(mem[rd_addr[9:0]]), .quad_io_enable_i(qen), .prot_en_i(prot_en),
        .prot_base_i(16'h0003), .arr_o(arr), .progress_flag_o(progress),
        .write_latch_flag_o(latch), .wrap_setting_bits_o(wrap));
    always @(posedge clk) begin
        if (arr.we) begin
            mem[arr.addr[9:0]] <= arr.data;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Expected read bytes follow the wrap section of len bytes, 0 for none
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                      input int nd, input int n, input int len);
        int ea;
        i_host.qread(op, a, m, nd, n);
        for (int k = 0; k < n; k++) begin
            ea = (len == 0) ? a + k : (a & ~(len - 1)) | ((a + k) & (len - 1));
            chk(i_host.rq[k], 8'(ea) ^ 8'h5A);
        end
    endtask
    task automatic prog(input logic [23:0] a, input int n, input int bits);
        i_host.start();
        i_host.put({8'h0, 8'h02, a}, 32, 1);
        for (int i = 0; i < n; i++) begin
            i_host.put({32'h0, 8'(i) ^ (i >= 256 ? 8'hC3 : 8'h00)}, 8, 1);
        end
        i_host.put(40'h0, bits, 1);
        i_host.stop();
    endtask
    task automatic wait_idle();
        int c = 0;
        while (progress !== 1'b0 && c < 1000) begin
            @(posedge clk);
            c++;
        end
        chk({7'h0, progress}, 8'h00);
    endtask
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = (i >= 256) ? 8'hFF : 8'(i) ^ 8'h5A;
        end
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        chk({5'h0, wrap}, 8'h01);
        chk({6'h0, latch, progress}, 8'h00);
        repeat (4) @(negedge clk);
        i_host.cmd({8'h77, 24'h0, 8'h20}, 40);
        chk({5'h0, wrap}, 8'h02);
        rd(8'hEB, 24'h00000E, 8'hA0, 4, 4, 16);
        rd(8'h00, 24'h000020, 8'h0F, 4, 2, 16);
        rd(8'hEB, 24'h000047, 8'h00, 4, 2, 16);
        i_host.cmd({8'h77, 24'h0, 8'h60}, 40);
        rd(8'hE7, 24'h00003E, 8'hA0, 2, 3, 64);
        rd(8'h00, 24'h000080, 8'hA0, 2, 2, 64);
        i_host.cmd(40'hFF, 8);
        rd(8'hEB, 24'h000090, 8'h00, 4, 2, 64);
        i_host.cmd({8'h77, 24'h0, 8'h10}, 40);
        rd(8'hEB, 24'h00003E, 8'h00, 4, 3, 0);
        @(negedge clk) qen = 1'b0;
        repeat (4) @(negedge clk);
        i_host.qread(8'hE7, 24'h000010, 8'h00, 2, 1);
        chk({7'h0, i_host.oe_seen}, 8'h00);
        @(negedge clk) qen = 1'b1;
        prog(24'h0001FE, 3, 0);
        chk({7'h0, progress}, 8'h00);
        i_host.cmd(40'h06, 8);
        chk({7'h0, latch}, 8'h01);
        prog(24'h0001FE, 3, 0);
        chk({6'h0, latch, progress}, 8'h01);
        wait_idle();
        chk(mem[10'h1FE], 8'h00);
        chk(mem[10'h100], 8'h02);
        chk(mem[10'h101], 8'hFF);
        i_host.cmd(40'h06, 8);
        prog(24'h000200, 258, 0);
        wait_idle();
        chk(mem[10'h200], 8'hC3);
        chk(mem[10'h202], 8'h02);
        for (int j = 0; j < 3; j++) begin
            @(negedge clk) prot_en = (j == 2);
            i_host.cmd(40'h06, 8);
            prog(24'h000300, (j == 0) ? 0 : 1, (j == 1) ? 4 : 0);
            chk({6'h0, latch, progress}, 8'h00);
            chk(mem[10'h300], 8'hFF);
        end
        report_and_stop();
    end
endmodule // quad_read_wrap_page_program_bench
